// ===== shared/ubmr_pkg.sv
/*
 Package for the miscellaneous and buffer-length register bank: command codes,
 reset values and the carriers that join the command decoder to the register bank.
 Assumes a 16-bit host data path and 8-bit command codes.
*/
package ubmr_pkg;

	localparam int unsigned DATA_WIDTH = 16;
	localparam int unsigned CODE_WIDTH = 8;

	// Read and write command codes
	localparam logic [7:0] CMD_IDENTITY_READ = 8'h27;
	localparam logic [7:0] CMD_SCRATCH_READ = 8'h28;
	localparam logic [7:0] CMD_SCRATCH_WRITE = 8'hA8;
	localparam logic [7:0] CMD_SOFT_RESET_WRITE = 8'hA9;
	localparam logic [7:0] CMD_ISO_LENGTH_READ = 8'h2A;
	localparam logic [7:0] CMD_ISO_LENGTH_WRITE = 8'hAA;
	localparam logic [7:0] CMD_APER_LENGTH_READ = 8'h2B;
	localparam logic [7:0] CMD_APER_LENGTH_WRITE = 8'hAB;

	localparam logic [15:0] SOFT_RESET_PATTERN = 16'h00F6;
	localparam logic [15:0] SCRATCH_RESET = 16'h0000;
	localparam logic [15:0] ISO_LENGTH_RESET = 16'h0000;
	localparam logic [15:0] APER_LENGTH_RESET = 16'h0000;
	localparam logic [15:0] READ_DATA_RESET = 16'h0000;
	localparam logic [15:0] BUFFER_RAM_BYTES = 16'h1000;

	// Arbitrary neutral identity; replace with the real product and revision
	localparam logic [7:0] IDENTITY_PRODUCT = 8'h5A;
	localparam logic [7:0] IDENTITY_REVISION = 8'h01;

	typedef enum logic [2:0] {
		UBMR_SEL_NONE,
		UBMR_SEL_IDENTITY,
		UBMR_SEL_SCRATCH,
		UBMR_SEL_SOFT_RESET,
		UBMR_SEL_ISO_LENGTH,
		UBMR_SEL_APER_LENGTH
	} ubmr_select_type;

	typedef struct packed {
		logic write;
		logic read;
		ubmr_select_type select;
	} ubmr_decode_type;

	typedef struct packed {
		logic [15:0] iso_length;
		logic [15:0] aperiodic_length;
		logic layout_fits;
	} ubmr_layout_type;

endpackage : ubmr_pkg

// ===== logic/ubmr_decode.sv
/*
 Command-code decoder for the register bank: maps one 8-bit command code to a
 register select and a read or write flag. Purely combinational; the caller
 qualifies the result with its own command strobe.
*/
`timescale 1ns/1ps
module ubmr_decode (
	input wire logic [7:0] i_code,
	output ubmr_pkg::ubmr_decode_type o_decode
);

	always_comb begin
		o_decode = '{write: 1'b0, read: 1'b0, select: ubmr_pkg::UBMR_SEL_NONE};
		case (i_code)
			ubmr_pkg::CMD_IDENTITY_READ: begin
				o_decode.read = 1'b1;
				o_decode.select = ubmr_pkg::UBMR_SEL_IDENTITY;
			end
			ubmr_pkg::CMD_SCRATCH_READ: begin
				o_decode.read = 1'b1;
				o_decode.select = ubmr_pkg::UBMR_SEL_SCRATCH;
			end
			ubmr_pkg::CMD_SCRATCH_WRITE: begin
				o_decode.write = 1'b1;
				o_decode.select = ubmr_pkg::UBMR_SEL_SCRATCH;
			end
			ubmr_pkg::CMD_SOFT_RESET_WRITE: begin
				o_decode.write = 1'b1;
				o_decode.select = ubmr_pkg::UBMR_SEL_SOFT_RESET;
			end
			ubmr_pkg::CMD_ISO_LENGTH_READ: begin
				o_decode.read = 1'b1;
				o_decode.select = ubmr_pkg::UBMR_SEL_ISO_LENGTH;
			end
			ubmr_pkg::CMD_ISO_LENGTH_WRITE: begin
				o_decode.write = 1'b1;
				o_decode.select = ubmr_pkg::UBMR_SEL_ISO_LENGTH;
			end
			ubmr_pkg::CMD_APER_LENGTH_READ: begin
				o_decode.read = 1'b1;
				o_decode.select = ubmr_pkg::UBMR_SEL_APER_LENGTH;
			end
			ubmr_pkg::CMD_APER_LENGTH_WRITE: begin
				o_decode.write = 1'b1;
				o_decode.select = ubmr_pkg::UBMR_SEL_APER_LENGTH;
			end
			default: begin
				o_decode.select = ubmr_pkg::UBMR_SEL_NONE;
			end
		endcase
	end

endmodule : ubmr_decode

// ===== logic/ubmr_regs.sv
/*
 Miscellaneous and buffer-length register bank of an embedded USB host controller.
 Assumes the host port logic of the controller core presents each command as a
 one-cycle strobe with code and write data on i_clock; read data is registered.
*/
// What this block does
// - Code 27 reads a fixed 16-bit identity word: product in the high byte, revision in the low byte.
// - A scratch word reads with code 28, writes with code A8, keeps the last write and resets to zero.
// - Writing F6H with code A9 resets the scratch and both length registers but leaves the buffer memory alone.
// - An isochronous length, read 2A and written AA, sizes both isochronous buffers alike and resets to zero.
// - An aperiodic length, read 2B and written AB, sets the aperiodic buffer size in bytes and resets to zero.
`timescale 1ns/1ps
module ubmr_regs #(
	parameter logic [7:0] PRODUCT_CODE = ubmr_pkg::IDENTITY_PRODUCT,
	parameter logic [7:0] REVISION_CODE = ubmr_pkg::IDENTITY_REVISION
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_command_strobe,
	input wire logic [7:0] i_command_code,
	input wire logic [15:0] i_write_data,
	output logic [15:0] o_read_data,
	output logic o_read_valid,
	output logic o_soft_reset,
	output ubmr_pkg::ubmr_layout_type o_layout
);

	ubmr_pkg::ubmr_decode_type decode;
	logic [15:0] scratch_reg;
	logic [15:0] iso_length_field;
	logic [15:0] aperiodic_length_field;
	logic soft_reset_pulse;
	logic write_hit;
	logic read_hit;
	logic [15:0] next_read_data;

	ubmr_decode u_decode (
		.i_code(i_command_code),
		.o_decode(decode)
	);

	assign write_hit = i_command_strobe && decode.write;
	assign read_hit = i_command_strobe && decode.read;

	function automatic logic [16:0] ubmr_layout_bytes(input logic [15:0] iso, input logic [15:0] aper);
		ubmr_layout_bytes = {1'b0, aper} + {iso, 1'b0};
	endfunction : ubmr_layout_bytes

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			soft_reset_pulse <= 1'b0;
		end else begin
			soft_reset_pulse <= write_hit && decode.select == ubmr_pkg::UBMR_SEL_SOFT_RESET
				&& i_write_data == ubmr_pkg::SOFT_RESET_PATTERN;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			scratch_reg <= ubmr_pkg::SCRATCH_RESET;
		end else if (soft_reset_pulse) begin
			scratch_reg <= ubmr_pkg::SCRATCH_RESET;
		end else if (write_hit && decode.select == ubmr_pkg::UBMR_SEL_SCRATCH) begin
			scratch_reg <= i_write_data;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			iso_length_field <= ubmr_pkg::ISO_LENGTH_RESET;
		end else if (soft_reset_pulse) begin
			iso_length_field <= ubmr_pkg::ISO_LENGTH_RESET;
		end else if (write_hit && decode.select == ubmr_pkg::UBMR_SEL_ISO_LENGTH) begin
			iso_length_field <= i_write_data;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			aperiodic_length_field <= ubmr_pkg::APER_LENGTH_RESET;
		end else if (soft_reset_pulse) begin
			aperiodic_length_field <= ubmr_pkg::APER_LENGTH_RESET;
		end else if (write_hit && decode.select == ubmr_pkg::UBMR_SEL_APER_LENGTH) begin
			aperiodic_length_field <= i_write_data;
		end
	end

	always_comb begin
		case (decode.select)
			ubmr_pkg::UBMR_SEL_IDENTITY: next_read_data = {PRODUCT_CODE, REVISION_CODE};
			ubmr_pkg::UBMR_SEL_SCRATCH: next_read_data = scratch_reg;
			ubmr_pkg::UBMR_SEL_ISO_LENGTH: next_read_data = iso_length_field;
			ubmr_pkg::UBMR_SEL_APER_LENGTH: next_read_data = aperiodic_length_field;
			default: next_read_data = ubmr_pkg::READ_DATA_RESET;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_read_data <= ubmr_pkg::READ_DATA_RESET;
			o_read_valid <= 1'b0;
		end else begin
			o_read_valid <= read_hit;
			if (read_hit) begin
				o_read_data <= next_read_data;
			end
		end
	end

	assign o_soft_reset = soft_reset_pulse;

	// Layout check flag
	// Only reported to the core; the device does not refuse an oversized layout.
	always_comb begin
		o_layout.iso_length = iso_length_field;
		o_layout.aperiodic_length = aperiodic_length_field;
		o_layout.layout_fits = ubmr_layout_bytes(iso_length_field, aperiodic_length_field)
			<= {1'b0, ubmr_pkg::BUFFER_RAM_BYTES};
	end

	property p_scratch_write;
		@(posedge i_clock) disable iff (!i_reset_n)
		(write_hit && decode.select == ubmr_pkg::UBMR_SEL_SCRATCH && !soft_reset_pulse)
			|=> scratch_reg == $past(i_write_data);
	endproperty
	a_scratch_write: assert property (p_scratch_write) else $error("scratch write lost");

	property p_soft_reset_fires;
		@(posedge i_clock) disable iff (!i_reset_n)
		(write_hit && decode.select == ubmr_pkg::UBMR_SEL_SOFT_RESET
			&& i_write_data == ubmr_pkg::SOFT_RESET_PATTERN)
			|=> o_soft_reset ##1 (scratch_reg == ubmr_pkg::SCRATCH_RESET
			&& iso_length_field == ubmr_pkg::ISO_LENGTH_RESET
			&& aperiodic_length_field == ubmr_pkg::APER_LENGTH_RESET);
	endproperty
	a_soft_reset_fires: assert property (p_soft_reset_fires) else $error("soft reset did not clear");

	property p_bad_pattern;
		@(posedge i_clock) disable iff (!i_reset_n)
		// A legal write may follow straight away, so stability is judged at the next edge only
		(write_hit && decode.select == ubmr_pkg::UBMR_SEL_SOFT_RESET
			&& i_write_data != ubmr_pkg::SOFT_RESET_PATTERN && !soft_reset_pulse)
			|=> !o_soft_reset && $stable(scratch_reg) && $stable(iso_length_field)
			&& $stable(aperiodic_length_field);
	endproperty
	a_bad_pattern: assert property (p_bad_pattern) else $error("bad pattern caused reset");

	property p_identity_read;
		@(posedge i_clock) disable iff (!i_reset_n)
		(read_hit && i_command_code == ubmr_pkg::CMD_IDENTITY_READ)
			|=> o_read_valid && o_read_data == {PRODUCT_CODE, REVISION_CODE};
	endproperty
	a_identity_read: assert property (p_identity_read) else $error("identity read wrong");

	property p_iso_read;
		@(posedge i_clock) disable iff (!i_reset_n)
		(read_hit && i_command_code == ubmr_pkg::CMD_ISO_LENGTH_READ)
			|=> o_read_data == $past(iso_length_field);
	endproperty
	a_iso_read: assert property (p_iso_read) else $error("iso length read wrong");

	property p_aper_write;
		@(posedge i_clock) disable iff (!i_reset_n)
		(write_hit && i_command_code == ubmr_pkg::CMD_APER_LENGTH_WRITE && !soft_reset_pulse)
			|=> aperiodic_length_field == $past(i_write_data);
	endproperty
	a_aper_write: assert property (p_aper_write) else $error("aperiodic length write lost");

	property p_layout_flag;
		@(posedge i_clock) disable iff (!i_reset_n)
		o_layout.layout_fits == (32'(aperiodic_length_field) + 32'(iso_length_field) * 2
			<= 32'(ubmr_pkg::BUFFER_RAM_BYTES));
	endproperty
	a_layout_flag: assert property (p_layout_flag) else $error("layout flag wrong");

	property p_scratch_read;
		@(posedge i_clock) disable iff (!i_reset_n)
		(read_hit && i_command_code == ubmr_pkg::CMD_SCRATCH_READ)
			|=> o_read_valid && o_read_data == $past(scratch_reg);
	endproperty
	a_scratch_read: assert property (p_scratch_read) else $error("scratch read wrong");

	property p_read_data_holds;
		@(posedge i_clock) disable iff (!i_reset_n)
		!read_hit |=> !o_read_valid && $stable(o_read_data);
	endproperty
	a_read_data_holds: assert property (p_read_data_holds) else $error("read data moved without a read");

	property p_iso_write;
		@(posedge i_clock) disable iff (!i_reset_n)
		(write_hit && i_command_code == ubmr_pkg::CMD_ISO_LENGTH_WRITE && !soft_reset_pulse)
			|=> iso_length_field == $past(i_write_data);
	endproperty
	a_iso_write: assert property (p_iso_write) else $error("iso length write lost");

	property p_aper_read;
		@(posedge i_clock) disable iff (!i_reset_n)
		(read_hit && i_command_code == ubmr_pkg::CMD_APER_LENGTH_READ)
			|=> o_read_valid && o_read_data == $past(aperiodic_length_field);
	endproperty
	a_aper_read: assert property (p_aper_read) else $error("aperiodic length read wrong");

	// A write landing in the pulse cycle is dropped: the reset has priority
	property p_reset_wins;
		@(posedge i_clock) disable iff (!i_reset_n)
		soft_reset_pulse |=> scratch_reg == ubmr_pkg::SCRATCH_RESET
			&& iso_length_field == ubmr_pkg::ISO_LENGTH_RESET
			&& aperiodic_length_field == ubmr_pkg::APER_LENGTH_RESET;
	endproperty
	a_reset_wins: assert property (p_reset_wins) else $error("register survived soft reset");

	property p_soft_reset_source;
		@(posedge i_clock) disable iff (!i_reset_n)
		o_soft_reset |-> $past(i_command_strobe) && $past(i_command_code) == ubmr_pkg::CMD_SOFT_RESET_WRITE
			&& $past(i_write_data) == ubmr_pkg::SOFT_RESET_PATTERN;
	endproperty
	a_soft_reset_source: assert property (p_soft_reset_source) else $error("soft reset without pattern");

endmodule : ubmr_regs

// ===== test/ubmr_host_model.sv
/*
 Host processor model: issues command strobes with code and data, one per cycle.
 Assumes the bench calls its tasks and shares the design clock.
*/
`timescale 1ns/1ps
module ubmr_host_model (
	input wire logic i_clock,
	output logic o_strobe,
	output logic [7:0] o_code,
	output logic [15:0] o_data
);
	initial begin
		o_strobe = 1'b0;
		o_code = 8'h00;
		o_data = 16'h0000;
	end

	task automatic send(input logic [7:0] code, input logic [15:0] data);
		@(posedge i_clock);
		o_strobe <= 1'b1;
		o_code <= code;
		o_data <= data;
	endtask : send

	// Released lines turn over so a stale value never looks live
	task automatic rest();
		@(posedge i_clock);
		o_strobe <= 1'b0;
		o_code <= ~o_code;
		o_data <= ~o_data;
	endtask : rest
endmodule : ubmr_host_model

// ===== test/ubmr_regs_test.sv
/*
 Self-checking bench for the register bank; read results are scored from a queue.
 Assumes reads answer one cycle after the strobe.
*/
`timescale 1ns/1ps
module ubmr_regs_test;
	logic i_clock = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_command_strobe;
	logic [7:0] i_command_code;
	logic [15:0] i_write_data;
	logic [15:0] o_read_data;
	logic o_read_valid;
	logic o_soft_reset;
	ubmr_pkg::ubmr_layout_type o_layout;
	logic [15:0] expect_q[$];
	logic [15:0] iso;
	logic [15:0] aper;
	int pulses = 0;
	int bad_count = 0;
	int checks_done = 0;

	always #5 i_clock = ~i_clock;

	ubmr_host_model host (.i_clock(i_clock), .o_strobe(i_command_strobe), .o_code(i_command_code),
		.o_data(i_write_data));
	ubmr_regs dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_command_strobe(i_command_strobe),
		.i_command_code(i_command_code), .i_write_data(i_write_data), .o_read_data(o_read_data),
		.o_read_valid(o_read_valid), .o_soft_reset(o_soft_reset), .o_layout(o_layout));

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", name, want, seen);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out

	task automatic rd(input logic [7:0] code, input logic [15:0] want);
		expect_q.push_back(want);
		host.send(code, 16'($urandom));
	endtask : rd

	task automatic settle(input int n);
		repeat (n) host.rest();
		#1;
	endtask : settle

	// Any read answer without a pending note is a stray
	always @(posedge i_clock) begin
		if (o_soft_reset === 1'b1) pulses++;
		if (o_read_valid === 1'b1) begin
			if (expect_q.size() == 0) check("stray read", 16'h0001, 16'h0000);
			else check("read data", o_read_data, expect_q.pop_front());
		end
	end

	initial begin
		#100000;
		bad_count++;
		close_out();
	end

	initial begin
		void'($urandom(32'hFA98));
		repeat (20) @(posedge i_clock);
		i_reset_n <= 1'b1;
		rd(ubmr_pkg::CMD_IDENTITY_READ, {ubmr_pkg::IDENTITY_PRODUCT, ubmr_pkg::IDENTITY_REVISION});
		rd(ubmr_pkg::CMD_SCRATCH_READ, 16'h0000);
		rd(ubmr_pkg::CMD_ISO_LENGTH_READ, 16'h0000);
		rd(ubmr_pkg::CMD_APER_LENGTH_READ, 16'h0000);
		for (int n = 0; n < 6; n++) begin
			iso = 16'($urandom_range(0, 32'h0800));
			aper = 16'($urandom_range(0, 32'h1000 - 2 * iso));
			host.send(ubmr_pkg::CMD_SCRATCH_WRITE, aper ^ iso);
			host.send(ubmr_pkg::CMD_ISO_LENGTH_WRITE, iso);
			host.send(ubmr_pkg::CMD_APER_LENGTH_WRITE, aper);
			rd(ubmr_pkg::CMD_SCRATCH_READ, aper ^ iso);
			rd(ubmr_pkg::CMD_ISO_LENGTH_READ, iso);
			rd(ubmr_pkg::CMD_APER_LENGTH_READ, aper);
		end
		settle(2);
		check("iso length", o_layout.iso_length, iso);
		check("aperiodic length", o_layout.aperiodic_length, aper);
		check("layout fits", 16'(o_layout.layout_fits), 16'h0001);
		host.send(ubmr_pkg::CMD_SOFT_RESET_WRITE, 16'h00F7);
		host.send(ubmr_pkg::CMD_SOFT_RESET_WRITE, 16'hF600);
		host.send(8'h2C, 16'h0000);
		host.send(8'hA7, 16'h00F6);
		settle(2);
		check("wrong pattern pulses", 16'(pulses), 16'h0000);
		rd(ubmr_pkg::CMD_SCRATCH_READ, aper ^ iso);
		rd(ubmr_pkg::CMD_ISO_LENGTH_READ, iso);
		rd(ubmr_pkg::CMD_APER_LENGTH_READ, aper);
		host.send(ubmr_pkg::CMD_SOFT_RESET_WRITE, ubmr_pkg::SOFT_RESET_PATTERN);
		settle(2);
		check("reset pulses", 16'(pulses), 16'h0001);
		rd(ubmr_pkg::CMD_SCRATCH_READ, 16'h0000);
		rd(ubmr_pkg::CMD_ISO_LENGTH_READ, 16'h0000);
		rd(ubmr_pkg::CMD_APER_LENGTH_READ, 16'h0000);
		rd(ubmr_pkg::CMD_IDENTITY_READ, {ubmr_pkg::IDENTITY_PRODUCT, ubmr_pkg::IDENTITY_REVISION});
		host.send(ubmr_pkg::CMD_ISO_LENGTH_WRITE, 16'h0001);
		host.send(ubmr_pkg::CMD_APER_LENGTH_WRITE, 16'h0FFE);
		settle(2);
		check("layout at limit", 16'(o_layout.layout_fits), 16'h0001);
		host.send(ubmr_pkg::CMD_APER_LENGTH_WRITE, 16'h0FFF);
		settle(2);
		check("layout over limit", 16'(o_layout.layout_fits), 16'h0000);
		settle(2);
		check("pending reads", 16'(expect_q.size()), 16'h0000);
		close_out();
	end
endmodule : ubmr_regs_test
